/* File: design/imu_regs_pkg.sv */
// Purpose: shared constants for the page-zero status and output registers
// Assumes: 16-bit serial frames, 7-bit byte addresses, byte-wide writes
// Notes:   addresses are byte addresses; a register spans two of them
package imu_regs_pkg;

  localparam int WORD_W      = 16;
  localparam int ADDR_W      = 7;
  localparam int AXES        = 3;
  localparam int SENSE_W     = 7;
  localparam int STORE_DEPTH = 13;
  localparam int STORE_IDX_W = 4;

  // register byte addresses
  localparam logic [6:0] OFF_PAGE_LOW   = 7'h00;
  localparam logic [6:0] OFF_PAGE_HIGH  = 7'h01;
  localparam logic [6:0] OFF_SYS_FLAGS  = 7'h08;
  localparam logic [6:0] OFF_SELFTEST   = 7'h0a;
  localparam logic [6:0] OFF_ALARM      = 7'h0c;
  localparam logic [6:0] OFF_TEMP       = 7'h0e;
  localparam logic [6:0] OFF_RATE_X_LOW = 7'h10;
  localparam logic [6:0] OFF_RATE_X_HI  = 7'h12;
  localparam logic [6:0] OFF_RATE_Y_LOW = 7'h14;
  localparam logic [6:0] OFF_RATE_Y_HI  = 7'h16;
  localparam logic [6:0] OFF_RATE_Z_LOW = 7'h18;
  localparam logic [6:0] OFF_RATE_Z_HI  = 7'h1a;
  localparam logic [6:0] OFF_ACC_X_LOW  = 7'h1c;
  localparam logic [6:0] OFF_ACC_X_HI   = 7'h1e;
  localparam logic [6:0] OFF_ACC_Y_LOW  = 7'h20;
  localparam logic [6:0] OFF_ACC_Y_HI   = 7'h22;
  localparam logic [6:0] OFF_ACC_Z_LOW  = 7'h24;
  localparam logic [6:0] OFF_ACC_Z_HI   = 7'h26;

  // reset values
  localparam logic [15:0] PAGE_RESET  = 16'h0000;
  localparam logic [15:0] FLAG_RESET  = 16'h0000;
  localparam logic [15:0] WORD_ZERO   = 16'h0000;
  localparam logic [15:0] PAGE_OUTPUT = 16'h0000;

  // per-sensor flag layout: six inertial bits at the bottom, barometer apart
  localparam int SENSE_BARO_IN = 6;
  localparam int FLAG_BARO_BIT = 11;
  localparam int SYS_ALARM_BIT = 0;
  localparam int SYS_CHECK_BIT = 5;

  // serial frame layout
  localparam int          FRAME_BITS  = 16;
  localparam logic [4:0]  FRAME_COUNT = 5'h10;
  localparam int          CMD_WR_BIT  = 15;

  // store entries
  localparam logic [3:0] IDX_TEMP   = 4'h0;
  localparam int         RATE_BASE  = 1;
  localparam int         ACCEL_BASE = 7;

  typedef enum {SPI_IDLE, SPI_FETCH, SPI_LOAD} spi_state_e;

endpackage : imu_regs_pkg

/* File: design/store_if.sv */
// Purpose: carrier between the register front end and the sample store
// Assumes: one writer, one store, same clock
// Notes:   the whole snapshot is written in one cycle
`timescale 1ns/1ps
interface store_if;
  logic                      wr_en;
  logic [12:0][15:0]         wr_data;
  logic [3:0]                rd_idx;
  logic [15:0]               rd_data;

  modport writer (output wr_en, output wr_data, output rd_idx,
                  input rd_data);
  modport store  (input wr_en, input wr_data, input rd_idx,
                  output rd_data);
endinterface : store_if

/* File: design/sample_store.sv */
// Purpose: snapshot store for temperature, rate and acceleration words
// Assumes: write and read indices come from the same clock domain
// Notes:   read data appear one cycle after the index
`timescale 1ns/1ps
module sample_store (
  // clock and reset
  input wire logic  clk_sys,
  input wire logic  rst,
  // front end
  store_if.store    port
);

  logic [15:0] mem_reg  [imu_regs_pkg::STORE_DEPTH];
  logic [15:0] mem_next [imu_regs_pkg::STORE_DEPTH];
  logic [15:0] rd_reg;
  logic [15:0] rd_next;

  // every word is written from one snapshot, so pairs stay coherent
  genvar e;
  generate
    for (e = 0; e < imu_regs_pkg::STORE_DEPTH; e++) begin : g_entry
      always_comb begin
        mem_next[e] = port.wr_en ? port.wr_data[e] : mem_reg[e];
      end
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          mem_reg[e] <= imu_regs_pkg::WORD_ZERO;
        end else begin
          mem_reg[e] <= mem_next[e];
        end
      end
      pair_capture_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        port.wr_en |=> mem_reg[e] == $past(port.wr_data[e]))
        else $error("store entry missed its snapshot");
    end
  endgenerate

  always_comb begin
    rd_next = imu_regs_pkg::WORD_ZERO;
    if (32'(port.rd_idx) < imu_regs_pkg::STORE_DEPTH) begin
      rd_next = mem_reg[port.rd_idx];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rd_reg <= imu_regs_pkg::WORD_ZERO;
    end else begin
      rd_reg <= rd_next;
    end
  end

  assign port.rd_data = rd_reg;

endmodule : sample_store

/* File: design/imu_status_and_output_regs.sv */
// Purpose: page-zero status flags and sensor output words behind the
//          serial register port
// Assumes: sensor words, fail and alarm levels come from on-chip logic
//          on clk_sys; serial pins are asynchronous
// Notes:   read answers are shifted out in the following frame
`timescale 1ns/1ps
module imu_status_and_output_regs (
  // clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  // serial register pins
  input  wire logic                   spi_cs_n,
  input  wire logic                   spi_sclk,
  input  wire logic                   spi_din,
  output logic                        spi_dout,
  // sensor samples
  input  wire logic                   sample_strobe,
  input  wire logic [15:0]            temp_sample,
  input  wire logic [2:0][31:0]       rate_sample,
  input  wire logic [2:0][31:0]       accel_sample,
  // condition levels
  input  wire logic [6:0]             selftest_fail,
  input  wire logic [6:0]             alarm_hit,
  input  wire logic                   check_fail
);

  localparam int PIN_CS   = 0;
  localparam int PIN_SCLK = 1;
  localparam int PIN_DIN  = 2;

  store_if sif ();

  sample_store u_store (
    .clk_sys (clk_sys),
    .rst     (rst),
    .port    (sif.store)
  );

  // pin synchroniser
  logic [2:0]  pin_meta_reg;
  logic [2:0]  pin_sync_reg;
  logic [2:0]  pin_prev_reg;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_meta_reg <= 3'h3;
      pin_sync_reg <= 3'h3;
      pin_prev_reg <= 3'h3;
    end else begin
      pin_meta_reg <= {spi_din, spi_sclk, spi_cs_n};
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  logic cs_active;
  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;

  assign cs_active = !pin_sync_reg[PIN_CS];
  assign cs_fall   = pin_prev_reg[PIN_CS] && !pin_sync_reg[PIN_CS];
  assign cs_rise   = !pin_prev_reg[PIN_CS] && pin_sync_reg[PIN_CS];
  assign sclk_rise = !pin_prev_reg[PIN_SCLK] && pin_sync_reg[PIN_SCLK];
  assign sclk_fall = pin_prev_reg[PIN_SCLK] && !pin_sync_reg[PIN_SCLK];

  // serial frame engine
  imu_regs_pkg::spi_state_e state_reg;
  imu_regs_pkg::spi_state_e state_next;
  logic [15:0] rx_reg;
  logic [15:0] rx_next;
  logic [15:0] tx_reg;
  logic [15:0] tx_next;
  logic [4:0]  cnt_reg;
  logic [4:0]  cnt_next;
  logic [15:0] cmd_reg;
  logic [15:0] cmd_next;
  logic [15:0] page_reg;
  logic [15:0] page_next;
  logic        dout_reg;
  logic        dout_next;

  logic [6:0]  cmd_addr;
  logic [6:0]  store_off;
  logic        cmd_write;
  logic        page_zero;
  logic        in_store;
  logic [15:0] read_word;
  logic        rd_selftest;
  logic        rd_alarm;
  logic        rd_sys;

  assign cmd_addr  = cmd_reg[14:8];
  assign cmd_write = cmd_reg[imu_regs_pkg::CMD_WR_BIT];
  assign page_zero = page_reg == imu_regs_pkg::PAGE_OUTPUT;
  assign store_off = cmd_addr - imu_regs_pkg::OFF_TEMP;
  assign in_store  = page_zero && cmd_addr >= imu_regs_pkg::OFF_TEMP
                     && cmd_addr <= imu_regs_pkg::OFF_ACC_Z_HI + 7'h01;

  // the register index ignores the byte bit: a word reads the same at both
  assign sif.rd_idx = store_off[4:1];

  // a read takes effect once the frame naming it has completed
  assign rd_selftest = state_reg == imu_regs_pkg::SPI_LOAD && !cmd_write
                       && page_zero
                       && cmd_addr[6:1] == imu_regs_pkg::OFF_SELFTEST[6:1];
  assign rd_alarm    = state_reg == imu_regs_pkg::SPI_LOAD && !cmd_write
                       && page_zero
                       && cmd_addr[6:1] == imu_regs_pkg::OFF_ALARM[6:1];
  assign rd_sys      = state_reg == imu_regs_pkg::SPI_LOAD && !cmd_write
                       && page_zero
                       && cmd_addr[6:1] == imu_regs_pkg::OFF_SYS_FLAGS[6:1];

  // status flag registers
  logic [15:0] selftest_reg;
  logic [15:0] selftest_next;
  logic [15:0] alarm_reg;
  logic [15:0] alarm_next;
  logic [15:0] sys_reg;
  logic [15:0] sys_next;
  logic [15:0] fail_word;
  logic [15:0] hit_word;

  always_comb begin
    fail_word = imu_regs_pkg::FLAG_RESET;
    hit_word  = imu_regs_pkg::FLAG_RESET;
    fail_word[5:0] = selftest_fail[5:0];
    fail_word[imu_regs_pkg::FLAG_BARO_BIT] =
      selftest_fail[imu_regs_pkg::SENSE_BARO_IN];
    // alarm_hit is the outcome of the configured alarm comparisons
    hit_word[5:0] = alarm_hit[5:0];
    hit_word[imu_regs_pkg::FLAG_BARO_BIT] =
      alarm_hit[imu_regs_pkg::SENSE_BARO_IN];
  end

  // set wins over a clearing read in the same cycle, so no event is lost
  always_comb begin
    selftest_next = rd_selftest ? imu_regs_pkg::FLAG_RESET
                                : selftest_reg;
    selftest_next = selftest_next | fail_word;
    alarm_next = rd_alarm ? imu_regs_pkg::FLAG_RESET : alarm_reg;
    if (sample_strobe) begin
      alarm_next = alarm_next | hit_word;
    end
    sys_next = rd_sys ? imu_regs_pkg::FLAG_RESET : sys_reg;
    if (sample_strobe && |alarm_hit) begin
      sys_next[imu_regs_pkg::SYS_ALARM_BIT] = 1'b1;
    end
    if (check_fail) begin
      sys_next[imu_regs_pkg::SYS_CHECK_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      selftest_reg <= imu_regs_pkg::FLAG_RESET;
      alarm_reg    <= imu_regs_pkg::FLAG_RESET;
      sys_reg      <= imu_regs_pkg::FLAG_RESET;
    end else begin
      selftest_reg <= selftest_next;
      alarm_reg    <= alarm_next;
      sys_reg      <= sys_next;
    end
  end

  // snapshot of all output words on one sample strobe
  assign sif.wr_en = sample_strobe;
  assign sif.wr_data[imu_regs_pkg::IDX_TEMP] = temp_sample;

  genvar a;
  generate
    for (a = 0; a < imu_regs_pkg::AXES; a++) begin : g_axis
      // low word first, high word (upper half) at the next address
      assign sif.wr_data[imu_regs_pkg::RATE_BASE + 2*a] =
        rate_sample[a][15:0];
      assign sif.wr_data[imu_regs_pkg::RATE_BASE + 2*a + 1] =
        rate_sample[a][31:16];
      assign sif.wr_data[imu_regs_pkg::ACCEL_BASE + 2*a] =
        accel_sample[a][15:0];
      assign sif.wr_data[imu_regs_pkg::ACCEL_BASE + 2*a + 1] =
        accel_sample[a][31:16];
    end
  endgenerate

  // read multiplexer; other pages belong to other blocks and read zero, all but the page word
  always_comb begin
    read_word = imu_regs_pkg::WORD_ZERO;
    if (cmd_addr[6:1] == imu_regs_pkg::OFF_PAGE_LOW[6:1]) begin
      read_word = page_reg;
    end else if (!page_zero) begin
      read_word = imu_regs_pkg::WORD_ZERO;
    end else if (cmd_addr[6:1] == imu_regs_pkg::OFF_SYS_FLAGS[6:1]) begin
      read_word = sys_reg;
    end else if (cmd_addr[6:1] == imu_regs_pkg::OFF_SELFTEST[6:1]) begin
      read_word = selftest_reg;
    end else if (cmd_addr[6:1] == imu_regs_pkg::OFF_ALARM[6:1]) begin
      read_word = alarm_reg;
    end else if (in_store) begin
      read_word = sif.rd_data;
    end
  end

  always_comb begin
    state_next = state_reg;
    rx_next    = rx_reg;
    tx_next    = tx_reg;
    cnt_next   = cnt_reg;
    cmd_next   = cmd_reg;
    page_next  = page_reg;
    dout_next  = tx_reg[imu_regs_pkg::FRAME_BITS-1];
    if (cs_fall) begin
      cnt_next = 5'h00;
    end else if (cs_active && sclk_rise) begin
      rx_next = {rx_reg[14:0], pin_sync_reg[PIN_DIN]};
      if (cnt_reg != 5'h1f) begin
        cnt_next = cnt_reg + 5'h01;
      end
    end else if (cs_active && sclk_fall && cnt_reg != 5'h00) begin
      // the first leading edge finds the top bit already on the line
      tx_next = {tx_reg[14:0], 1'b0};
    end
    unique case (state_reg)
      imu_regs_pkg::SPI_IDLE: begin
        // a frame that is not exactly sixteen bits is dropped
        if (cs_rise && cnt_reg == imu_regs_pkg::FRAME_COUNT) begin
          cmd_next   = rx_reg;
          state_next = imu_regs_pkg::SPI_FETCH;
        end
      end
      imu_regs_pkg::SPI_FETCH: begin
        if (cmd_write) begin
          if (cmd_addr == imu_regs_pkg::OFF_PAGE_LOW) begin
            page_next[7:0] = cmd_reg[7:0];
          end else if (cmd_addr == imu_regs_pkg::OFF_PAGE_HIGH) begin
            page_next[15:8] = cmd_reg[7:0];
          end
          state_next = imu_regs_pkg::SPI_IDLE;
        end else begin
          state_next = imu_regs_pkg::SPI_LOAD;
        end
      end
      imu_regs_pkg::SPI_LOAD: begin
        tx_next    = read_word;
        state_next = imu_regs_pkg::SPI_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg <= imu_regs_pkg::SPI_IDLE;
      rx_reg    <= imu_regs_pkg::WORD_ZERO;
      tx_reg    <= imu_regs_pkg::WORD_ZERO;
      cnt_reg   <= 5'h00;
      cmd_reg   <= imu_regs_pkg::WORD_ZERO;
      page_reg  <= imu_regs_pkg::PAGE_RESET;
      dout_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      rx_reg    <= rx_next;
      tx_reg    <= tx_next;
      cnt_reg   <= cnt_next;
      cmd_reg   <= cmd_next;
      page_reg  <= page_next;
      dout_reg  <= dout_next;
    end
  end

  assign spi_dout = dout_reg;

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence st_read_s;
    rd_selftest && selftest_fail == 7'h00;
  endsequence

  sequence alarm_read_s;
    rd_alarm && !sample_strobe;
  endsequence

  sequence page_write_s;
    state_reg == imu_regs_pkg::SPI_FETCH && cmd_write
      && cmd_addr == imu_regs_pkg::OFF_PAGE_LOW;
  endsequence

  selftest_clear_a: assert property (
    st_read_s |=> selftest_reg == imu_regs_pkg::FLAG_RESET)
    else $error("self-test flags not cleared by read");

  selftest_reset_a: assert property (
    (selftest_fail != 7'h00) |=> selftest_reg != imu_regs_pkg::FLAG_RESET)
    else $error("persisting self-test failure not flagged");

  selftest_layout_a: assert property (
    selftest_reg[10:6] == 5'h00 && selftest_reg[15:12] == 4'h0)
    else $error("unused self-test bit set");

  alarm_layout_a: assert property (
    $past(alarm_hit[imu_regs_pkg::SENSE_BARO_IN] && sample_strobe)
      |-> alarm_reg[imu_regs_pkg::FLAG_BARO_BIT] && alarm_reg[10:6] == 5'h00)
    else $error("barometer alarm in wrong bit");

  alarm_clear_a: assert property (
    alarm_read_s |=> alarm_reg == imu_regs_pkg::FLAG_RESET)
    else $error("alarm flags not cleared by read");

  alarm_reset_a: assert property (
    sample_strobe && alarm_hit[0] |=> alarm_reg[0]
      ##1 (alarm_reg[0] || $past(rd_alarm)))
    else $error("persisting alarm not set in next sample");

  sys_alarm_a: assert property (
    sample_strobe && |alarm_hit |=> sys_reg[imu_regs_pkg::SYS_ALARM_BIT])
    else $error("system alarm bit missing");

  sys_check_a: assert property (
    check_fail |=> sys_reg[imu_regs_pkg::SYS_CHECK_BIT])
    else $error("self test outcome bit missing");

  page_write_a: assert property (
    page_write_s |=> page_reg[7:0] == $past(cmd_reg[7:0]))
    else $error("page select not written");

  frame_load_a: assert property (
    cs_rise && cnt_reg == imu_regs_pkg::FRAME_COUNT
      && !rx_reg[imu_regs_pkg::CMD_WR_BIT]
      |=> state_reg == imu_regs_pkg::SPI_FETCH
      ##1 state_reg == imu_regs_pkg::SPI_LOAD)
    else $error("read frame not answered");

endmodule : imu_status_and_output_regs

/* File: tb/spi_host_model.sv */
// Purpose: host side of the serial register port, mode 3 frames
// Assumes: caller enters tasks just after a clk_sys rising edge
// Notes:   phases of 4 cycles keep clear of the 3-cycle pin synchroniser
`timescale 1ns/1ps
module spi_host_model (
  // clock
  input  wire logic clk_sys,
  // serial pins
  output logic      spi_cs_n,
  output logic      spi_sclk,
  output logic      spi_din,
  input  wire logic spi_dout
);
  initial begin
    spi_cs_n = 1'b1;
    spi_sclk = 1'b1;
    spi_din  = 1'b0;
  end

  task automatic gap(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : gap

  // one frame of 16 bits; rx collects the word of the previous frame
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    rx = 16'h0000;
    gap(1);
    spi_cs_n = 1'b0;
    gap(4);
    for (int i = 15; i >= 0; i--) begin
      spi_sclk = 1'b0;
      spi_din  = tx[i];
      gap(4);
      spi_sclk = 1'b1;
      rx = {rx[14:0], spi_dout};
      gap(4);
    end
    spi_cs_n = 1'b1;
    // released line shows the inverse so a stale level cannot pass
    spi_din = ~spi_din;
    // long gap: the answer loads several cycles after the frame ends
    gap(12);
  endtask : xfer
endmodule : spi_host_model

/* File: tb/imu_status_and_output_regs_bench.sv */
// Purpose: self-checking bench for the page-zero status and output words
// Assumes: host model drives the serial pins; bench drives sensor inputs
// Notes:   each read costs two frames, the second returns the word
`timescale 1ns/1ps
module imu_status_and_output_regs_bench;
  logic              clk_sys;
  logic              rst;
  logic              spi_cs_n;
  logic              spi_sclk;
  logic              spi_din;
  logic              spi_dout;
  logic              sample_strobe;
  logic [15:0]       temp_sample;
  logic [2:0][31:0]  rate_s;
  logic [2:0][31:0]  accel_s;
  logic [6:0]        selftest_fail;
  logic [6:0]        alarm_hit;
  logic              check_fail;
  int                failures;
  int                tests_run;
  logic [15:0]       junk;

  imu_status_and_output_regs u_imu_status_and_output_regs (
    .clk_sys(clk_sys), .rst(rst), .spi_cs_n(spi_cs_n),
    .spi_sclk(spi_sclk), .spi_din(spi_din), .spi_dout(spi_dout),
    .sample_strobe(sample_strobe), .temp_sample(temp_sample),
    .rate_sample(rate_s), .accel_sample(accel_s),
    .selftest_fail(selftest_fail), .alarm_hit(alarm_hit),
    .check_fail(check_fail));

  spi_host_model u_spi_host_model (
    .clk_sys(clk_sys), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
    .spi_din(spi_din), .spi_dout(spi_dout));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic finish_test();
    if (failures == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test

  task automatic check(input string n, input logic [15:0] seen,
                       input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask : check

  task automatic rd_chk(input string n, input logic [6:0] a,
                        input logic [15:0] e);
    logic [15:0] d;
    u_spi_host_model.xfer({1'b0, a, 8'h00}, d);
    u_spi_host_model.xfer(16'h0000, d);
    check(n, d, e);
  endtask : rd_chk

  task automatic strobe();
    @(posedge clk_sys);
    #1 sample_strobe = 1'b1;
    @(posedge clk_sys);
    #1 sample_strobe = 1'b0;
  endtask : strobe

  task automatic test_reset_values();
    rd_chk("selftest", imu_regs_pkg::OFF_SELFTEST, 16'h0000);
    rd_chk("alarm", imu_regs_pkg::OFF_ALARM, 16'h0000);
    rd_chk("page", imu_regs_pkg::OFF_PAGE_LOW, 16'h0000);
    rd_chk("unmapped", 7'h04, 16'h0000);
  endtask : test_reset_values

  task automatic test_selftest();
    selftest_fail = 7'h55;
    rd_chk("st map", imu_regs_pkg::OFF_SELFTEST, 16'h0815);
    rd_chk("st persist", imu_regs_pkg::OFF_SELFTEST, 16'h0815);
    selftest_fail = 7'h00;
    rd_chk("st last", imu_regs_pkg::OFF_SELFTEST, 16'h0815);
    rd_chk("st clear", imu_regs_pkg::OFF_SELFTEST, 16'h0000);
  endtask : test_selftest

  // reading status discards flags, so each read here is deliberate
  task automatic test_alarm();
    alarm_hit = 7'h4a;
    rd_chk("al wait", imu_regs_pkg::OFF_ALARM, 16'h0000);
    strobe();
    rd_chk("al map", imu_regs_pkg::OFF_ALARM, 16'h080a);
    rd_chk("al clear", imu_regs_pkg::OFF_ALARM, 16'h0000);
    strobe();
    rd_chk("al again", imu_regs_pkg::OFF_ALARM, 16'h080a);
    alarm_hit = 7'h00;
    strobe();
    rd_chk("al gone", imu_regs_pkg::OFF_ALARM, 16'h0000);
  endtask : test_alarm

  task automatic test_system_flags();
    check_fail = 1'b1;
    rd_chk("sys both", imu_regs_pkg::OFF_SYS_FLAGS, 16'h0021);
    check_fail = 1'b0;
    rd_chk("sys check", imu_regs_pkg::OFF_SYS_FLAGS, 16'h0020);
    rd_chk("sys clear", imu_regs_pkg::OFF_SYS_FLAGS, 16'h0000);
  endtask : test_system_flags

  task automatic test_words();
    logic [6:0] a;
    temp_sample = 16'hd310;
    rate_s  = {32'ha81c0001, 32'hffffffff, 32'h57e40000};
    accel_s = {32'h00000002, 32'hb1e00000, 32'h4e200000};
    strobe();
    rd_chk("temp", imu_regs_pkg::OFF_TEMP, 16'hd310);
    for (int i = 0; i < 3; i++) begin
      a = imu_regs_pkg::OFF_RATE_X_LOW + 7'(4 * i);
      rd_chk("rate lo", a, rate_s[i][15:0]);
      rd_chk("rate hi", a + 7'h02, rate_s[i][31:16]);
      a = imu_regs_pkg::OFF_ACC_X_LOW + 7'(4 * i);
      rd_chk("acc lo", a, accel_s[i][15:0]);
      rd_chk("acc hi", a + 7'h02, accel_s[i][31:16]);
    end
    // new input without a sample cycle must not tear the stored pair
    rate_s[0] = 32'h12345678;
    rd_chk("hold lo", imu_regs_pkg::OFF_RATE_X_LOW, 16'h0000);
    rd_chk("hold hi", imu_regs_pkg::OFF_RATE_X_HI, 16'h57e4);
    strobe();
    rd_chk("new lo", imu_regs_pkg::OFF_RATE_X_LOW, 16'h5678);
    rd_chk("odd hi", 7'h13, 16'h1234);
  endtask : test_words

  task automatic test_page();
    u_spi_host_model.xfer(16'h8002, junk);
    rd_chk("pg other", imu_regs_pkg::OFF_RATE_X_HI, 16'h0000);
    rd_chk("pg word", imu_regs_pkg::OFF_PAGE_LOW, 16'h0002);
    u_spi_host_model.xfer(16'h8000, junk);
    rd_chk("pg zero", imu_regs_pkg::OFF_RATE_X_HI, 16'h1234);
  endtask : test_page

  // a reset in mid-run must bring the page word back to zero
  task automatic test_mid_reset();
    u_spi_host_model.xfer(16'h8002, junk);
    @(posedge clk_sys);
    #1 rst = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 rst = 1'b0;
    repeat (4) @(posedge clk_sys);
    #1;
    rd_chk("rst page", imu_regs_pkg::OFF_PAGE_LOW, 16'h0000);
  endtask : test_mid_reset

  initial begin
    failures      = 0;
    tests_run     = 0;
    rst           = 1'b1;
    sample_strobe = 1'b0;
    temp_sample   = 16'h0000;
    rate_s        = '0;
    accel_s       = '0;
    selftest_fail = 7'h00;
    alarm_hit     = 7'h00;
    check_fail    = 1'b0;
    repeat (8) @(posedge clk_sys);
    #1 rst = 1'b0;
    repeat (4) @(posedge clk_sys);
    #1;
    test_reset_values();
    test_selftest();
    test_alarm();
    test_system_flags();
    test_words();
    test_page();
    test_mid_reset();
    finish_test();
  end

  // about 80 frames of 150 cycles each; allow three times that
  initial begin
    #300000;
    failures++;
    finish_test();
  end
endmodule : imu_status_and_output_regs_bench
